// file: dv/adc_comparator_model.sv
// Behavioural analog side: channel levels and the comparator
`timescale 1ns/1ps
`default_nettype none
module adc_comparator_model (
    // Design side
    input wire logic [15:0] chan_switch,
    input wire logic [7:0] trial_code,
    output logic comparator_high
);
    // ========================================================================
    // Comparator
    logic [7:0] level;
    // Input n sits at code 0f+16n; with all switches open the external level feeds in
    always_comb begin
        level = 8'ha5;
        for (int i = 0; i < 16; i++) begin
            if (chan_switch[i]) begin
                level = 8'h0f + 8'(i * 16);
            end
        end
        comparator_high = (level >= trial_code); // Tap at or below input keeps the bit
    end
endmodule // adc_comparator_model
`default_nettype wire

// file: dv/test_adc_mux_sar_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module test_adc_mux_sar_control;
    import adc_ctl_pkg::*;
    // ========================================================================
    // Signals
    localparam int HOLD = 88; // 8 clocks plus 2 us, clock is above the slow limit
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] chan_addr = 4'h0;
    logic addr_latch = 1'b0;
    logic expansion_on = 1'b1;
    logic trig = 1'b0;
    logic loop_on = 1'b0;
    logic output_enable = 1'b1;
    logic comparator_high, conversion_trigger, conv_done_q;
    logic [15:0] chan_switch_q;
    logic [7:0] trial_code_q, data_out_q, data_oe_q;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    // Free-running mode wires completion back to the trigger
    assign conversion_trigger = loop_on ? conv_done_q : trig;
    // ========================================================================
    // Design and analog side
    adc_mux_sar_control i_dut (.clock(clock), .sys_rst(sys_rst), .chan_addr(chan_addr),
        .addr_latch(addr_latch), .expansion_on(expansion_on), .chan_switch_q(chan_switch_q),
        .conversion_trigger(conversion_trigger), .comparator_high(comparator_high),
        .trial_code_q(trial_code_q), .conv_done_q(conv_done_q),
        .output_enable(output_enable), .data_out_q(data_out_q), .data_oe_q(data_oe_q));
    adc_comparator_model i_cmp (.chan_switch(chan_switch_q), .trial_code(trial_code_q),
        .comparator_high(comparator_high));
    // Clock and hang guard; a hang ends the run as a failure
    initial begin
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    // ========================================================================
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic sel(input logic [3:0] a);
        @(posedge clock);
        chan_addr <= a;
        addr_latch <= 1'b1;
        @(posedge clock);
        addr_latch <= 1'b0;
        cyc(3);
    endtask
    // Trigger pulse; a held trigger must not start the trials
    task automatic pulse();
        @(posedge clock);
        trig <= 1'b1;
        cyc(8);
        @(negedge clock);
        `chk(conv_done_q, 1'b0)
        `chk(trial_code_q, 8'h00)
        cyc(HOLD - 8);
        trig <= 1'b0;
    endtask
    // Full conversion: exactly 8 trials and a load before completion
    task automatic conv(input logic [7:0] exp);
        pulse();
        cyc(10);
        @(negedge clock);
        `chk(conv_done_q, 1'b0)
        `chk(data_out_q, exp)
        @(negedge clock);
        `chk(conv_done_q, 1'b1)
        cyc(2);
        @(negedge clock);
        `chk(data_out_q, exp)
        `chk(conv_done_q, 1'b1)
        `chk(data_oe_q, 8'hff)
    endtask
    task automatic t_chan();
        for (int n = 0; n < 16; n++) begin
            sel(4'(n));
            @(negedge clock);
            `chk(chan_switch_q, CHAN_ONE << n)
        end
        @(posedge clock);
        chan_addr <= 4'h3;
        cyc(3);
        @(negedge clock);
        `chk(chan_switch_q, 16'h8000)
        @(posedge clock);
        expansion_on <= 1'b0;
        cyc(2);
        @(negedge clock);
        `chk(chan_switch_q, CHAN_OFF)
    endtask
    task automatic t_free();
        int rises;
        logic prev;
        rises = 0;
        prev = 1'b1;
        @(posedge clock);
        loop_on <= 1'b1; // Kicked by done still high from the last conversion
        repeat (60) begin
            @(negedge clock);
            if (conv_done_q === 1'b1 && prev === 1'b0) rises++;
            prev = conv_done_q;
        end
        `chk(rises >= 3, 1'b1)
        @(posedge clock);
        loop_on <= 1'b0;
    endtask
    // Dropping the drive enable takes the pins off the bus a clock later
    task automatic t_oe_off();
        @(posedge clock);
        output_enable <= 1'b0;
        cyc(2);
        @(negedge clock);
        `chk(data_oe_q, 8'h00)
    endtask
    task automatic complete_run();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ========================================================================
    // Main sequence
    initial begin
        cyc(5);
        sys_rst <= 1'b0;
        t_chan();
        conv(8'ha5);
        @(posedge clock);
        expansion_on <= 1'b1;
        sel(4'h0);
        conv(8'h0f);
        sel(4'hf);
        conv(8'hff);
        sel(4'h6);
        pulse();
        cyc(4);
        conv(8'h6f);
        t_oe_off();
        t_free();
        complete_run();
    end
endmodule // test_adc_mux_sar_control
`default_nettype wire

// file: hdl/adc_ctl_pkg.sv
// Constants and types for the multiplexed successive-approximation converter control
package adc_ctl_pkg;
    // ========================================================================
    // Sizes
    localparam int unsigned RES_BITS = 8;
    localparam int unsigned ADDR_BITS = 4;
    localparam int unsigned CHAN_COUNT = 16;
    // ========================================================================
    // Timing
    localparam int unsigned EOC_LOW_MAX_CYC = 8;
    localparam logic [3:0] BIT_TOP = 4'h7;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    // ========================================================================
    // Reset values and the one-hot channel base
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [3:0] ADDR_RST = 4'h0;
    localparam logic [15:0] CHAN_OFF = 16'h0000;
    localparam logic [15:0] CHAN_ONE = 16'h0001;
    // Sequencer states, gray along idle -> armed -> trial -> load
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_TRIAL = 2'b11,
        ST_LOAD = 2'b10
    } seq_state_e;
endpackage : adc_ctl_pkg

// file: hdl/adc_mux_sar_control.sv
// Channel latch, bit-trial sequencer and result latch of the converter
`timescale 1ns/1ps
`default_nettype none
module adc_mux_sar_control
    import adc_ctl_pkg::*;
#(
    parameter int unsigned WIDTH = RES_BITS,
    parameter int unsigned CHANNELS = CHAN_COUNT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Channel selection
    input wire logic [ADDR_BITS-1:0] chan_addr,
    input wire logic addr_latch,
    input wire logic expansion_on,
    output logic [CHANNELS-1:0] chan_switch_q,
    // Conversion control
    input wire logic conversion_trigger,
    input wire logic comparator_high,
    output logic [WIDTH-1:0] trial_code_q,
    output logic conv_done_q,
    // Result bus, three-state as three signals
    input wire logic output_enable,
    output logic [WIDTH-1:0] data_out_q,
    output logic [WIDTH-1:0] data_oe_q
);
    // ========================================================================
    // Input edge detection
    logic ale_prev_q;
    logic trig_prev_q;
    logic ale_rise;
    logic trig_rise;
    logic trig_fall;
    logic [ADDR_BITS-1:0] addr_q;
    seq_state_e state_q;
    logic [3:0] bit_idx_q;
    logic [WIDTH-1:0] bit_trial_register_q;
    logic loaded_q;

    // One-hot switch pattern for a channel index, shared by the decode and its check
    function automatic logic [CHANNELS-1:0] onehot_chan(input logic [ADDR_BITS-1:0] idx);
        return CHANNELS'(CHAN_ONE) << idx;
    endfunction

    // Inputs are synchronous, so one stage of history is enough for edges
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ale_prev_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            ale_prev_q <= addr_latch;
            trig_prev_q <= conversion_trigger;
        end
    end

    assign ale_rise = addr_latch & ~ale_prev_q;
    assign trig_rise = conversion_trigger & ~trig_prev_q;
    assign trig_fall = ~conversion_trigger & trig_prev_q;

    // ========================================================================
    // Address latch and one-hot channel decode
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            addr_q <= ADDR_RST;
        end else if (ale_rise) begin
            addr_q <= chan_addr;
        end
    end

    // Switches follow latch and expansion a cycle later; expansion low opens all
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            chan_switch_q <= CHAN_OFF;
        end else if (expansion_on) begin
            chan_switch_q <= onehot_chan(addr_q);
        end else begin
            chan_switch_q <= CHAN_OFF;
        end
    end

    // ========================================================================
    // Bit-trial sequencer
    // A rise anywhere restarts, so a running trial is abandoned without a result.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            bit_idx_q <= BIT_TOP;
            bit_trial_register_q <= RESULT_RST;
        end else if (trig_rise) begin
            state_q <= ST_ARMED;
            bit_idx_q <= BIT_TOP;
            bit_trial_register_q <= RESULT_RST;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                ST_ARMED: begin
                    // Wait for the falling edge; holding high does nothing
                    if (trig_fall) begin
                        state_q <= ST_TRIAL;
                        bit_trial_register_q[BIT_TOP[2:0]] <= 1'b1;
                    end
                end
                ST_TRIAL: begin
                    // Keep the trial bit when input is at or above the ladder tap
                    bit_trial_register_q[bit_idx_q[2:0]] <= comparator_high;
                    if (bit_idx_q == BIT_ZERO) begin
                        state_q <= ST_LOAD;
                    end else begin
                        bit_trial_register_q[bit_idx_q[2:0] - 3'd1] <= 1'b1;
                        bit_idx_q <= bit_idx_q - 4'd1;
                    end
                end
                ST_LOAD: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign trial_code_q = bit_trial_register_q;

    // ========================================================================
    // Output data register, loaded in ST_LOAD one clock before done rises
    // Loading the pin register itself keeps the data a full clock ahead of done,
    // so a reader that latches on the rising done edge never sees the old code.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            data_out_q <= RESULT_RST;
        end else if (state_q == ST_LOAD && !trig_rise) begin
            data_out_q <= bit_trial_register_q;
        end
    end

    // Marks the clock after the load; an abandoned load never raises done
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= (state_q == ST_LOAD) && !trig_rise;
        end
    end

    // Done falls one clock after the trigger rise, rises one clock after the load.
    // The clear wins over the set, since a new pulse must always pull done low.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            conv_done_q <= 1'b0;
        end else if (trig_rise) begin
            conv_done_q <= 1'b0;
        end else if (loaded_q) begin
            conv_done_q <= 1'b1;
        end
    end

    // ========================================================================
    // Output drive enable, the same for every pin
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            data_oe_q <= RESULT_RST;
        end else begin
            data_oe_q <= {WIDTH{output_enable}};
        end
    end

    // ========================================================================
    // Checks
    // Checks that a new pulse may cut short name the trigger rise in their guard.
    property p_done_low;
        @(posedge clock) disable iff (sys_rst)
        trig_rise |-> ##[1:8] !conv_done_q;
    endproperty
    a_done_low: assert property (p_done_low)
        else $error("done not low after trigger");

    property p_clear;
        @(posedge clock) disable iff (sys_rst)
        trig_rise |=> bit_trial_register_q == RESULT_RST;
    endproperty
    a_clear: assert property (p_clear) else $error("trial register not cleared");

    property p_wait_fall;
        @(posedge clock) disable iff (sys_rst)
        (state_q == ST_ARMED && conversion_trigger) |=> state_q != ST_TRIAL;
    endproperty
    a_wait_fall: assert property (p_wait_fall)
        else $error("trial started while high");

    property p_eight;
        @(posedge clock) disable iff (sys_rst || trig_rise)
        (state_q == ST_ARMED && trig_fall) |=> (state_q == ST_TRIAL) [*8] ##1 state_q == ST_LOAD;
    endproperty
    a_eight: assert property (p_eight) else $error("not eight trials");

    property p_load_before_done;
        @(posedge clock) disable iff (sys_rst)
        (state_q == ST_LOAD && !trig_rise)
            |=> (data_out_q == $past(bit_trial_register_q) && !conv_done_q)
            ##1 (conv_done_q || $past(trig_rise));
    endproperty
    a_load_before_done: assert property (p_load_before_done)
        else $error("result late");

    property p_done_hold;
        @(posedge clock) disable iff (sys_rst)
        (conv_done_q && !trig_rise) |=> conv_done_q;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done dropped early");

    property p_latch;
        @(posedge clock) disable iff (sys_rst)
        (expansion_on && !ale_rise) ##1 (expansion_on && !ale_rise)
            |=> chan_switch_q == onehot_chan($past(addr_q));
    endproperty
    a_latch: assert property (p_latch) else $error("channel decode wrong");

    property p_off;
        @(posedge clock) disable iff (sys_rst)
        !expansion_on |=> chan_switch_q == CHAN_OFF;
    endproperty
    a_off: assert property (p_off) else $error("switch on while expansion low");

    property p_oe;
        @(posedge clock) disable iff (sys_rst)
        1'b1 |=> data_oe_q == {WIDTH{$past(output_enable)}};
    endproperty
    a_oe: assert property (p_oe) else $error("drive enable wrong");

    property p_restart;
        @(posedge clock) disable iff (sys_rst)
        (state_q == ST_TRIAL && trig_rise) |=> state_q == ST_ARMED && !conv_done_q;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

    property p_one_hot;
        @(posedge clock) disable iff (sys_rst)
        expansion_on |=> $onehot(chan_switch_q);
    endproperty
    a_one_hot: assert property (p_one_hot)
        else $error("not exactly one switch on");

    property p_addr_hold;
        @(posedge clock) disable iff (sys_rst)
        !ale_rise |=> addr_q == $past(addr_q);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved without strobe");

    property p_data_first;
        @(posedge clock) disable iff (sys_rst)
        $rose(conv_done_q) |-> $stable(data_out_q);
    endproperty
    a_data_first: assert property (p_data_first)
        else $error("data changed with done");

    property p_msb_first;
        @(posedge clock) disable iff (sys_rst)
        (state_q == ST_ARMED && trig_fall) |=> trial_code_q == {1'b1, {(WIDTH-1){1'b0}}};
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first trial not on top bit");

    property p_rise_arms;
        @(posedge clock) disable iff (sys_rst)
        trig_rise |=> state_q == ST_ARMED;
    endproperty
    a_rise_arms: assert property (p_rise_arms)
        else $error("rise did not arm");

    property p_done_quiet;
        @(posedge clock) disable iff (sys_rst)
        (!conv_done_q && !loaded_q) |=> !conv_done_q;
    endproperty
    a_done_quiet: assert property (p_done_quiet)
        else $error("done rose without a result");

    property p_idle_stay;
        @(posedge clock) disable iff (sys_rst)
        (state_q == ST_IDLE && !trig_rise) |=> state_q == ST_IDLE;
    endproperty
    a_idle_stay: assert property (p_idle_stay)
        else $error("left idle without trigger");

    property p_bit_step;
        @(posedge clock) disable iff (sys_rst)
        (state_q == ST_TRIAL && !trig_rise && bit_idx_q != BIT_ZERO)
            |=> state_q == ST_TRIAL && bit_idx_q == $past(bit_idx_q) - 4'd1;
    endproperty
    a_bit_step: assert property (p_bit_step)
        else $error("trial bit skipped");
endmodule // adc_mux_sar_control
`default_nettype wire
